// [verilog/fault_mgmt_pkg.sv]
// Shared constants, types and helpers for the thermal and external fault block
package fault_mgmt_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL    = 8'h00;
  localparam logic [7:0] OFS_DRIVE_THR  = 8'h04;
  localparam logic [7:0] OFS_MOTOR1_THR = 8'h08;
  localparam logic [7:0] OFS_MOTOR2_THR = 8'h0C;
  localparam logic [7:0] OFS_MOTOR3_THR = 8'h10;
  localparam logic [7:0] OFS_STATUS     = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h1C;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h20;

  // ==========================================================================
  // Control register field positions
  localparam int CTL_ALARM_EN_BIT = 0;
  localparam int CTL_SOURCE_LSB   = 2;
  localparam int CTL_POLARITY_BIT = 4;
  localparam int CTL_REACTION_LSB = 8;
  localparam int CTL_SOFT_BIT     = 12;

  // Status register field positions
  localparam int STS_PENDING_LSB  = 0;
  localparam int STS_LOCKED_LSB   = 4;
  localparam int STS_EXT_BIT      = 8;

  // Interrupt bit positions
  localparam int IRQ_DEFERRED_BIT = 0;
  localparam int IRQ_LOCK_BIT     = 1;
  localparam int IRQ_RELEASE_BIT  = 2;
  localparam int IRQ_EXT_BIT      = 3;
  localparam int IRQ_WIDTH        = 4;

  // ==========================================================================
  // Threshold limits and values after reset, in percent of rated state
  localparam logic [7:0] THR_MAX         = 8'h76;
  localparam logic [7:0] THR_RESET       = 8'h64;
  localparam logic [7:0] RELEASE_MARGIN  = 8'h14;
  localparam int         CHANNELS        = 4;

  // ==========================================================================
  // Modes
  typedef enum logic [1:0] {
    SRC_UNASSIGNED,
    SRC_LOGIC_INPUT_ONE,
    SRC_SOFT_BIT
  } ext_source_e;

  typedef enum logic [2:0] {
    REACT_IGNORE,
    REACT_FREEWHEEL,
    REACT_PER_STOP_TYPE,
    REACT_FALLBACK_SPEED,
    REACT_SPEED_MAINTAIN,
    REACT_RAMP_STOP,
    REACT_FAST_STOP,
    REACT_DC_INJECTION
  } ext_reaction_e;

  localparam logic       POLARITY_RESET = 1'b1;
  localparam logic [1:0] SOURCE_RESET   = 2'h0;
  localparam logic [2:0] REACTION_RESET = 3'h1;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [7:0] drive;
    logic [7:0] motor1;
    logic [7:0] motor2;
    logic [7:0] motor3;
  } thermal_states_s;

  typedef struct packed {
    logic          alarm_stop_enable;
    ext_source_e   source;
    logic          polarity_high;
    ext_reaction_e reaction;
    logic          soft_fault_bit;
  } fault_config_s;

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] clamp_threshold(input logic [7:0] value);
    clamp_threshold = (value > THR_MAX) ? THR_MAX : value;
  endfunction

  function automatic logic [7:0] release_level(input logic [7:0] threshold);
    release_level = (threshold > RELEASE_MARGIN) ? threshold - RELEASE_MARGIN : 8'h00;
  endfunction

endpackage

// [verilog/thermal_channel.sv]
// One thermal threshold channel: deferred stop and lock with release hysteresis
`timescale 1ns/1ps
`default_nettype none

module thermal_channel (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       enable,
  input  wire logic       drive_running,
  input  wire logic [7:0] thermal_state,
  input  wire logic [7:0] threshold,
  output logic            pending,
  output logic            locked
);
  import fault_mgmt_pkg::*;

  typedef enum logic [1:0] {
    CH_IDLE,
    CH_DEFERRED,
    CH_LOCKED
  } channel_state_e;

  channel_state_e state;
  channel_state_e next_state;

  wire logic reached;
  wire logic released;

  assign reached  = thermal_state >= threshold;
  assign released = thermal_state <= release_level(threshold);

  always_comb begin
    next_state = state;
    unique case (state)
      CH_IDLE: begin
        if (enable && reached) begin
          next_state = drive_running ? CH_DEFERRED : CH_LOCKED;
        end
      end
      CH_DEFERRED: begin
        if (!enable) begin
          next_state = CH_IDLE;
        end else if (!drive_running) begin
          next_state = CH_LOCKED;
        end
      end
      CH_LOCKED: begin
        if (!enable || released) begin
          next_state = CH_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= CH_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign pending = state == CH_DEFERRED;
  assign locked  = state == CH_LOCKED;

endmodule

`default_nettype wire

// [verilog/ext_fault_detect.sv]
// External fault source selection, pin synchroniser and edge trip
`timescale 1ns/1ps
`default_nettype none

module ext_fault_detect (
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire logic                          logic_input_one,
  input  wire fault_mgmt_pkg::fault_config_s cfg,
  output logic                               active,
  output logic                               trip
);
  import fault_mgmt_pkg::*;

  logic sync_meta;
  logic sync_pin;
  logic pin_prev;
  logic soft_prev;

  wire logic pin_asserted;
  wire logic pin_edge;
  wire logic soft_edge;
  wire logic next_active;

  // Polarity only matters for the pin; the soft bit is always high-true
  assign pin_asserted = cfg.polarity_high ? sync_pin : !sync_pin;
  assign pin_edge     = cfg.polarity_high ? (sync_pin && !pin_prev)
                                          : (!sync_pin && pin_prev);
  assign soft_edge    = cfg.soft_fault_bit && !soft_prev;

  assign trip = (cfg.source == SRC_LOGIC_INPUT_ONE && pin_edge) ||
                (cfg.source == SRC_SOFT_BIT && soft_edge);

  // Edge starts the fault, the level keeps it; a pin already asserted at
  // power-up does not trip until it has been released once
  assign next_active = trip ||
                       (active && cfg.source == SRC_LOGIC_INPUT_ONE && pin_asserted) ||
                       (active && cfg.source == SRC_SOFT_BIT && cfg.soft_fault_bit);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_meta <= 1'b0;
      sync_pin  <= 1'b0;
      pin_prev  <= 1'b0;
      soft_prev <= 1'b0;
      active    <= 1'b0;
    end else begin
      sync_meta <= logic_input_one;
      sync_pin  <= sync_meta;
      pin_prev  <= sync_pin;
      soft_prev <= cfg.soft_fault_bit;
      active    <= next_active;
    end
  end

endmodule

`default_nettype wire

// [verilog/thermal_fault_mgr.sv]
// Top: AHB-Lite register slave, thermal deferred stop and external fault trip
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Overheat while running defers stop to next stop
// - Lock after stop until state 20 below threshold
// - Separate drive and motor thresholds, own states
// - Disabled hides thresholds; enabled gives freewheel stop
// - Threshold reached while enabled trips with freewheel
// - Drive threshold 0 to 118, reset 100
// - Three motor thresholds 0 to 118, reset 100
// - Assigned fault bit: 0 none, 1 fault
// - Source resets unassigned; polarity only for pin
// - Low polarity trips falling, high trips rising
// - External fault reaction selectable, freewheel by default
module thermal_fault_mgr (
  input  wire logic                            hclk,
  input  wire logic                            hresetn,
  input  wire logic                            hsel,
  input  wire logic [31:0]                     haddr,
  input  wire logic [1:0]                      htrans,
  input  wire logic                            hwrite,
  input  wire logic [2:0]                      hsize,
  input  wire logic [31:0]                     hwdata,
  input  wire logic                            hready,
  output logic      [31:0]                     hrdata,
  output logic                                 hreadyout,
  output logic                                 hresp,
  input  wire fault_mgmt_pkg::thermal_states_s thermal_states,
  input  wire logic                            drive_running,
  input  wire logic                            logic_input_one,
  output logic                                 thermal_alarm_pending,
  output logic                                 thermal_lock,
  output logic                                 thermal_freewheel_stop,
  output logic                                 ext_fault_active,
  output fault_mgmt_pkg::ext_reaction_e        ext_fault_stop,
  output logic                                 irq
);
  import fault_mgmt_pkg::*;

  // ==========================================================================
  // Configuration registers
  logic                 thermal_alarm_stop_enable;
  ext_source_e          external_fault_source;
  logic                 external_fault_polarity;
  ext_reaction_e        external_fault_reaction;
  logic                 external_fault_bit;
  logic [7:0]           drive_thermal_threshold;
  logic [7:0]           motor1_thermal_threshold;
  logic [7:0]           motor2_thermal_threshold;
  logic [7:0]           motor3_thermal_threshold;
  logic [IRQ_WIDTH-1:0] irq_status;
  logic [IRQ_WIDTH-1:0] irq_enable;

  // Data-phase state of the bus
  logic                 wr_pending;
  logic [7:0]           wr_offset;

  // ==========================================================================
  // Bus decode
  wire logic            addr_phase;
  wire logic            wr_take;
  wire logic            wr_control;
  wire logic            wr_thr_ok;
  wire logic [7:0]      wr_thr_value;
  wire logic [31:0]     read_value;
  wire fault_config_s   cfg;

  // Single whole-word transfers only; narrower sizes are answered the same way
  assign addr_phase   = hsel && hready && htrans[1];
  assign wr_take      = wr_pending;
  assign wr_control   = wr_take && wr_offset == OFS_CONTROL;
  // Thresholds are frozen and hidden while the function is off
  assign wr_thr_ok    = wr_take && thermal_alarm_stop_enable;
  assign wr_thr_value = clamp_threshold(hwdata[7:0]);

  assign cfg.alarm_stop_enable = thermal_alarm_stop_enable;
  assign cfg.source            = external_fault_source;
  assign cfg.polarity_high     = external_fault_polarity;
  assign cfg.reaction          = external_fault_reaction;
  assign cfg.soft_fault_bit    = external_fault_bit;

  // ==========================================================================
  // Thermal channels, each against its own state
  wire logic [CHANNELS-1:0] ch_pending;
  wire logic [CHANNELS-1:0] ch_locked;
  wire logic [7:0]          ch_state [CHANNELS];
  wire logic [7:0]          ch_thr   [CHANNELS];

  assign ch_state[0] = thermal_states.drive;
  assign ch_state[1] = thermal_states.motor1;
  assign ch_state[2] = thermal_states.motor2;
  assign ch_state[3] = thermal_states.motor3;
  assign ch_thr[0]   = drive_thermal_threshold;
  assign ch_thr[1]   = motor1_thermal_threshold;
  assign ch_thr[2]   = motor2_thermal_threshold;
  assign ch_thr[3]   = motor3_thermal_threshold;

  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_channel
      // Compare every cycle; defer while running, lock at stop
      thermal_channel u_channel (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .enable        (thermal_alarm_stop_enable),
        .drive_running (drive_running),
        .thermal_state (ch_state[gi]),
        .threshold     (ch_thr[gi]),
        .pending       (ch_pending[gi]),
        .locked        (ch_locked[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // External fault
  wire logic ext_active_raw;
  wire logic ext_trip;

  // Source select, sync and edge polarity
  ext_fault_detect u_ext (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .logic_input_one (logic_input_one),
    .cfg             (cfg),
    .active          (ext_active_raw),
    .trip            (ext_trip)
  );

  wire logic          ext_effective;
  wire ext_reaction_e next_ext_stop;

  assign ext_effective = ext_active_raw && external_fault_reaction != REACT_IGNORE;
  assign next_ext_stop = ext_effective ? external_fault_reaction : REACT_IGNORE;

  // ==========================================================================
  // Events and interrupts
  logic                      any_locked_prev;
  logic                      any_pending_prev;
  wire logic                 any_locked;
  wire logic                 any_pending;
  wire logic [IRQ_WIDTH-1:0] irq_events;
  wire logic [IRQ_WIDTH-1:0] irq_clear;
  wire logic [IRQ_WIDTH-1:0] next_irq_status;

  assign any_locked  = |ch_locked;
  assign any_pending = |ch_pending;

  assign irq_events[IRQ_DEFERRED_BIT] = any_pending && !any_pending_prev;
  assign irq_events[IRQ_LOCK_BIT]     = any_locked && !any_locked_prev;
  assign irq_events[IRQ_RELEASE_BIT]  = !any_locked && any_locked_prev;
  assign irq_events[IRQ_EXT_BIT]      = ext_trip && external_fault_reaction != REACT_IGNORE;

  assign irq_clear = (wr_take && wr_offset == OFS_IRQ_CLEAR) ? hwdata[IRQ_WIDTH-1:0]
                                                             : '0;
  // A new event outranks a clear in the same cycle
  assign next_irq_status = (irq_status & ~irq_clear) | irq_events;

  // ==========================================================================
  // Read mux
  wire logic [7:0] rd_offset;
  wire logic [31:0] status_word;
  wire logic [31:0] control_word;

  assign rd_offset = haddr[7:0];

  assign control_word = {19'h0,
                         external_fault_bit,
                         1'b0,
                         external_fault_reaction,
                         3'h0,
                         external_fault_polarity,
                         external_fault_source,
                         1'b0,
                         thermal_alarm_stop_enable};

  assign status_word = {23'h0, ext_active_raw, ch_locked, ch_pending};

  assign read_value =
      (rd_offset == OFS_CONTROL)                                  ? control_word :
      (rd_offset == OFS_DRIVE_THR  && thermal_alarm_stop_enable)  ?
          {24'h0, drive_thermal_threshold} :
      (rd_offset == OFS_MOTOR1_THR && thermal_alarm_stop_enable)  ?
          {24'h0, motor1_thermal_threshold} :
      (rd_offset == OFS_MOTOR2_THR && thermal_alarm_stop_enable)  ?
          {24'h0, motor2_thermal_threshold} :
      (rd_offset == OFS_MOTOR3_THR && thermal_alarm_stop_enable)  ?
          {24'h0, motor3_thermal_threshold} :
      (rd_offset == OFS_STATUS)                                   ? status_word :
      (rd_offset == OFS_IRQ_STATUS)                               ?
          {28'h0, irq_status} :
      (rd_offset == OFS_IRQ_ENABLE)                               ?
          {28'h0, irq_enable} :
      32'h0000_0000;

  // ==========================================================================
  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      wr_offset  <= 8'h00;
      hrdata     <= 32'h0000_0000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else begin
      wr_pending <= addr_phase && hwrite;
      wr_offset  <= addr_phase ? haddr[7:0] : wr_offset;
      hrdata     <= (addr_phase && !hwrite) ? read_value : 32'h0000_0000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end
  end

  // ==========================================================================
  // Control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      thermal_alarm_stop_enable <= 1'b0;
      external_fault_source     <= ext_source_e'(SOURCE_RESET);
      external_fault_polarity   <= POLARITY_RESET;
      external_fault_reaction   <= ext_reaction_e'(REACTION_RESET);
      external_fault_bit        <= 1'b0;
    end else if (wr_control) begin
      thermal_alarm_stop_enable <= hwdata[CTL_ALARM_EN_BIT];
      external_fault_source     <= ext_source_e'(hwdata[CTL_SOURCE_LSB +: 2]);
      // Polarity is locked unless the pin is the source
      if (ext_source_e'(hwdata[CTL_SOURCE_LSB +: 2]) == SRC_LOGIC_INPUT_ONE) begin
        external_fault_polarity <= hwdata[CTL_POLARITY_BIT];
      end
      external_fault_reaction   <= ext_reaction_e'(hwdata[CTL_REACTION_LSB +: 3]);
      external_fault_bit        <= hwdata[CTL_SOFT_BIT];
    end
  end

  // ==========================================================================
  // Threshold registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_thermal_threshold  <= THR_RESET;
      motor1_thermal_threshold <= THR_RESET;
      motor2_thermal_threshold <= THR_RESET;
      motor3_thermal_threshold <= THR_RESET;
    end else if (wr_thr_ok) begin
      if (wr_offset == OFS_DRIVE_THR) begin
        drive_thermal_threshold <= wr_thr_value;
      end
      if (wr_offset == OFS_MOTOR1_THR) begin
        motor1_thermal_threshold <= wr_thr_value;
      end
      if (wr_offset == OFS_MOTOR2_THR) begin
        motor2_thermal_threshold <= wr_thr_value;
      end
      if (wr_offset == OFS_MOTOR3_THR) begin
        motor3_thermal_threshold <= wr_thr_value;
      end
    end
  end

  // ==========================================================================
  // Interrupt registers and registered outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status       <= '0;
      irq_enable       <= '0;
      any_locked_prev  <= 1'b0;
      any_pending_prev <= 1'b0;
      irq              <= 1'b0;
    end else begin
      irq_status       <= next_irq_status;
      irq_enable       <= (wr_take && wr_offset == OFS_IRQ_ENABLE) ?
                          hwdata[IRQ_WIDTH-1:0] : irq_enable;
      any_locked_prev  <= any_locked;
      any_pending_prev <= any_pending;
      irq              <= |(next_irq_status & irq_enable);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      thermal_alarm_pending  <= 1'b0;
      thermal_lock           <= 1'b0;
      thermal_freewheel_stop <= 1'b0;
      ext_fault_active       <= 1'b0;
      ext_fault_stop         <= REACT_IGNORE;
    end else begin
      thermal_alarm_pending  <= any_pending;
      thermal_lock           <= any_locked;
      thermal_freewheel_stop <= any_locked;
      ext_fault_active       <= ext_effective;
      ext_fault_stop         <= next_ext_stop;
    end
  end

endmodule

`default_nettype wire

// [test/thermal_fault_mgr_monitor.sv]
// Port checks for the thermal deferred stop and external fault block
`timescale 1ns/1ps
`default_nettype none
// ======================================
// Checker
module thermal_fault_mgr_monitor (
  input wire logic                          hclk,
  input wire logic                          hresetn,
  input wire logic                          hreadyout,
  input wire logic                          hresp,
  input wire logic                          drive_running,
  input wire logic                          thermal_alarm_pending,
  input wire logic                          thermal_lock,
  input wire logic                          thermal_freewheel_stop,
  input wire logic                          ext_fault_active,
  input wire fault_mgmt_pkg::ext_reaction_e ext_fault_stop
);
  import fault_mgmt_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Stop while deferred: the lock must follow within the pipeline depth
  sequence s_stop_pending;
    thermal_alarm_pending && !drive_running;
  endsequence
  sequence s_lock_soon;
    ##[1:3] thermal_lock;
  endsequence
  a_ready_always: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_defer_lock: assert property (s_stop_pending |-> s_lock_soon)
    else $error("no lock after stop");
  a_pend_running: assert property ($rose(thermal_alarm_pending) |-> $past(drive_running, 2))
    else $error("deferral while stopped");
  a_lock_stopped: assert property ($rose(thermal_lock) |-> !$past(drive_running, 2))
    else $error("lock while running");
  a_fw_lock: assert property (thermal_freewheel_stop == thermal_lock)
    else $error("freewheel differs from lock");
  a_ext_idle: assert property (!ext_fault_active |-> ext_fault_stop == REACT_IGNORE)
    else $error("stop code without fault");
  a_ext_code: assert property (ext_fault_active |-> ext_fault_stop != REACT_IGNORE)
    else $error("fault with ignore code");
endmodule

bind thermal_fault_mgr thermal_fault_mgr_monitor i_mon (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .drive_running(drive_running), .thermal_alarm_pending(thermal_alarm_pending),
  .thermal_lock(thermal_lock), .thermal_freewheel_stop(thermal_freewheel_stop),
  .ext_fault_active(ext_fault_active), .ext_fault_stop(ext_fault_stop)
);
`default_nettype wire

// [test/thermal_source_model.sv]
// Thermal estimators and external fault pin driving the block
`timescale 1ns/1ps
`default_nettype none
// ======================================
// Partner model
module thermal_source_model (
  input  wire logic                            hclk,
  input  wire logic                            slow,
  input  wire fault_mgmt_pkg::thermal_states_s target,
  input  wire logic                            pin_level,
  output fault_mgmt_pkg::thermal_states_s      thermal_states,
  output logic                                 logic_input_one
);
  import fault_mgmt_pkg::*;
  logic [3:0][7:0] cur = '0;
  logic [3:0][7:0] tgt;
  assign tgt = target;
  assign thermal_states = cur;
  initial logic_input_one = 1'b0;
  // Slow mode moves one point a cycle, like a filtered estimate
  always @(posedge hclk) begin
    for (int i = 0; i < 4; i++) begin
      if (!slow || cur[i] == tgt[i])
        cur[i] <= tgt[i];
      else
        cur[i] <= (cur[i] < tgt[i]) ? cur[i] + 8'h01 : cur[i] - 8'h01;
    end
    logic_input_one <= pin_level;
  end
endmodule
`default_nettype wire

// [test/tb_thermal_deferred_stop_ext_fault.sv]
// Self-checking bench for the thermal deferred stop and external fault block
`timescale 1ns/1ps
`default_nettype none
// ======================================
// Bench top
module tb_thermal_deferred_stop_ext_fault;
  import fault_mgmt_pkg::*;
  logic            hclk = 1'b0;
  logic            hresetn = 1'b0;
  logic            hsel = 1'b0;
  logic [31:0]     haddr = '0;
  logic [1:0]      htrans = '0;
  logic            hwrite = 1'b0;
  logic [31:0]     hwdata = '0;
  logic            drive_running = 1'b0;
  logic            pin = 1'b0;
  logic            slow = 1'b0;
  logic [3:0][7:0] tgt = '0;
  logic [31:0]     hrdata;
  logic [31:0]     q;
  logic            hreadyout, hresp, lin, pend, lock, fw, ext_act, irq;
  thermal_states_s states;
  ext_reaction_e   ext_stop;
  int              fail_count = 0;
  int              compares = 0;
  int              thr[4];
  always #50 hclk = ~hclk;

  thermal_fault_mgr i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .thermal_states(states), .irq(irq),
    .drive_running(drive_running), .logic_input_one(lin), .thermal_alarm_pending(pend),
    .thermal_lock(lock), .thermal_freewheel_stop(fw), .ext_fault_active(ext_act),
    .ext_fault_stop(ext_stop)
  );
  thermal_source_model i_src (
    .hclk(hclk), .slow(slow), .target(tgt), .pin_level(pin),
    .thermal_states(states), .logic_input_one(lin)
  );

  // ======================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic outs(input logic p, input logic l);
    chk({29'h0, pend, lock, fw}, {29'h0, p, l, l});
  endtask
  task automatic ext(input logic a, input logic [2:0] c);
    chk({28'h0, ext_act, ext_stop}, {28'h0, a, c});
  endtask
  task automatic finish_test;
    $display("Mismatches %0d of %0d comparisons", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #(100 * 5000);
    fail_count++;
    finish_test();
  end

  // ======================================
  // Scenarios
  initial begin
    void'($urandom(8));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(OFS_CONTROL, 32'h110);
    rd(OFS_MOTOR1_THR, 32'h0);
    rd(8'h30, 32'h0);
    xfer(1'b1, OFS_CONTROL, 32'h1);
    for (int i = 0; i < 4; i++)
      rd(OFS_DRIVE_THR + 8'(4 * i), 32'h64);
    xfer(1'b1, OFS_DRIVE_THR, 32'hFF);
    rd(OFS_DRIVE_THR, 32'h76);
    // Above 20 so every lock has a nonzero release point
    for (int i = 1; i < 4; i++) begin
      thr[i] = 21 + $urandom % 98;
      xfer(1'b1, OFS_DRIVE_THR + 8'(4 * i), 32'(thr[i]));
      rd(OFS_DRIVE_THR + 8'(4 * i), 32'(thr[i]));
    end
    xfer(1'b1, OFS_DRIVE_THR, 32'h50);
    xfer(1'b1, OFS_IRQ_ENABLE, 32'hF);
    drive_running <= 1'b1;
    tgt[3] <= 8'h4F;
    tick(6);
    outs(1'b0, 1'b0);
    tgt[3] <= 8'h50;
    tick(6);
    outs(1'b1, 1'b0);
    rd(OFS_IRQ_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b1, OFS_IRQ_CLEAR, 32'hF);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    drive_running <= 1'b0;
    tick(6);
    outs(1'b0, 1'b1);
    tgt[3] <= 8'h3D;
    tick(6);
    outs(1'b0, 1'b1);
    tgt[3] <= 8'h3C;
    tick(6);
    outs(1'b0, 1'b0);
    rd(OFS_IRQ_STATUS, 32'h6);
    xfer(1'b1, OFS_IRQ_ENABLE, 32'h8);
    rd(OFS_IRQ_ENABLE, 32'h8);
    rd(OFS_IRQ_CLEAR, 32'h0);
    xfer(1'b1, OFS_IRQ_CLEAR, 32'hF);
    slow <= 1'b1;
    for (int i = 1; i < 4; i++) begin
      tgt[3 - i] <= 8'(thr[i] - 1);
      tick(125);
      outs(1'b0, 1'b0);
      tgt[3 - i] <= 8'(thr[i]);
      tick(6);
      outs(1'b0, 1'b1);
      rd(OFS_STATUS, 32'h1 << (4 + i));
      tgt[3 - i] <= 8'(thr[i] - 20);
      tick(30);
      outs(1'b0, 1'b0);
    end
    rd(OFS_IRQ_STATUS, 32'h6);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, OFS_IRQ_CLEAR, 32'hF);
    for (int r = 0; r < 8; r++) begin
      xfer(1'b1, OFS_CONTROL, 32'h14 | 32'(r << 8));
      pin <= 1'b1;
      tick(8);
      ext(r != 0, 3'(r));
      pin <= 1'b0;
      tick(8);
      ext(1'b0, 3'h0);
    end
    rd(OFS_IRQ_STATUS, 32'h8);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b1, OFS_CONTROL, 32'h104);
    pin <= 1'b1;
    tick(8);
    ext(1'b0, 3'h0);
    pin <= 1'b0;
    tick(8);
    ext(1'b1, 3'h1);
    xfer(1'b1, OFS_CONTROL, 32'h110);
    rd(OFS_CONTROL, 32'h100);
    pin <= 1'b1;
    tick(8);
    ext(1'b0, 3'h0);
    xfer(1'b1, OFS_CONTROL, 32'h1108);
    tick(6);
    ext(1'b1, 3'h1);
    xfer(1'b1, OFS_CONTROL, 32'h108);
    tick(6);
    ext(1'b0, 3'h0);
    // Threshold writes dropped while off; source code 3 acts as none
    xfer(1'b1, OFS_DRIVE_THR, 32'h10);
    xfer(1'b1, OFS_CONTROL, 32'h110D);
    tick(6);
    ext(1'b0, 3'h0);
    rd(OFS_DRIVE_THR, 32'h50);
    // Mid-run reset: outputs clear, bus stays ready
    hresetn <= 1'b0;
    tick(2);
    chk({30'h0, irq, hreadyout}, 32'h1);
    outs(1'b0, 1'b0);
    hresetn <= 1'b1;
    tick(1);
    rd(OFS_CONTROL, 32'h110);
    rd(OFS_DRIVE_THR, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
